// ===== tnr_regs.svh
// Constants for the targeted neighbour refresh and row repair block.
// Assumes a 25 MHz aclk; all counts derive from the times below.
`ifndef TNR_REGS_SVH
`define TNR_REGS_SVH
// Mode register indexes as carried on the command bus
`define TNR_IDX_REFCTL 6'h04
`define TNR_IDX_ROWREF 6'h18
`define TNR_IDX_REPAIR 6'h19
// Own register indexes, bus byte address is four times the index
`define TNR_IDX_STATUS 6'h20
`define TNR_IDX_REFCNT 6'h21
// Field positions
`define TNR_ROWREF_EN 7
`define TNR_ROWREF_BANK_HI 6
`define TNR_ROWREF_BANK_LO 4
`define TNR_REFCTL_REPAIR 4
// Reset values
`define TNR_ROWREF_RST 8'h00
`define TNR_REFCTL_RST 8'h00
// Clock period and times
`define TNR_CLK_NS 40
`define TNR_T_MRD_NS 20
`define TNR_T_RP_NS 21
`define TNR_T_PGM_MS 1000
`define TNR_T_PGM_EXIT_NS 15
`define TNR_T_PGMPST_US 50
// Least times, rounded up to whole cycles
`define TNR_MRD_CYC ((`TNR_T_MRD_NS + `TNR_CLK_NS - 1) / `TNR_CLK_NS)
`define TNR_RP_CYC ((`TNR_T_RP_NS + `TNR_CLK_NS - 1) / `TNR_CLK_NS)
`define TNR_PGM_CYC ((`TNR_T_PGM_MS * 1000000 + `TNR_CLK_NS - 1) / `TNR_CLK_NS)
`define TNR_EXIT_CYC ((`TNR_T_PGM_EXIT_NS + `TNR_CLK_NS - 1) / `TNR_CLK_NS)
`define TNR_PST_CYC ((`TNR_T_PGMPST_US * 1000 + `TNR_CLK_NS - 1) / `TNR_CLK_NS)
`endif

// ===== tnr_pkg.sv
// Types for the targeted neighbour refresh and row repair block.
// Commands arrive already decoded from the two-edge command bus.
package tnr_pkg;
   // Decoded command kinds
   typedef enum logic [3:0] {
      TNR_CMD_NOP = 4'h0,
      TNR_CMD_ACT = 4'h1,
      TNR_CMD_PRE = 4'h2,
      TNR_CMD_PRECHARGE_ALL_BANKS = 4'h3,
      TNR_CMD_REF = 4'h4,
      TNR_CMD_SRE = 4'h5,
      TNR_CMD_MRW = 4'h6,
      TNR_CMD_RDWR = 4'h7,
      TNR_CMD_RESET = 4'h8
   } tnr_op_t;
   // One decoded command
   typedef struct packed {
      logic valid;
      tnr_op_t op;
      logic [2:0] bank;
      logic [16:0] row;
      logic [5:0] ma;
      logic [7:0] data;
   } tnr_cmd_t;
   // Targeted refresh flow states
   typedef enum logic [2:0] {
      TNR_TRR_IDLE = 3'b000,
      TNR_TRR_ENTRY = 3'b001,
      TNR_TRR_RUN = 3'b010,
      TNR_TRR_DONE = 3'b011,
      TNR_TRR_BROKEN = 3'b100,
      TNR_TRR_CLEAR = 3'b101
   } tnr_trr_t;
   // Row repair states
   typedef enum logic [3:0] {
      TNR_PPR_IDLE = 4'h0,
      TNR_PPR_MRD = 4'h1,
      TNR_PPR_ARMED = 4'h2,
      TNR_PPR_PGM = 4'h3,
      TNR_PPR_WAITPRE = 4'h4,
      TNR_PPR_EXIT = 4'h5,
      TNR_PPR_WAITCLR = 4'h6,
      TNR_PPR_PST = 4'h7,
      TNR_PPR_NEEDRST = 4'h8
   } tnr_ppr_t;
endpackage : tnr_pkg

// ===== tnr_maint.sv
// Maintenance sequencer of the memory die: targeted neighbour refresh and fuse row repair.
// Assumes decoded commands one per cycle on aclk and an AXI4-Lite master for software.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "tnr_regs.svh"

// Operation
// [R1] Controller caps aggressor activations per period
// [R2] Enable bit seven, bank in bits 6:4
// [R3] Controller keeps mode off during calibration
// [R4] Only disable write allowed while mode runs
// [R5] Enable self-clears after third precharge plus delay
// [R6] Disable write exits; bank bits ignored
// [R7] Three activates, three precharges; all-bank counts
// [R8] Entry from idle by single write
// [R9] Quiet until delay; then bank only activate/precharge
// [R10] Other banks idle until second activate
// [R11] Precharge, then second activate precharge-time later
// [R12] Second and third pairs follow row-active timing
// [R13] Quiet after third precharge until completion
// [R14] Interrupt cleared by disable plus three precharges
// [R15] No refresh or self refresh during mode
// [R16] Mode activates leave refresh counter unchanged
// [R17] Normal timings and activate window still apply
// [R18] Neighbour rows refreshed on completion
// [R19] One fused repair per bank, readable
// [R20] Repair: enable, wait, activate, program, precharge
// [R21] Exit wait, disable, wait, reset required
// [R22] Controller guards against accidental repair entry
// [R23] No commands during fuse programming
// [R24] Contents invalid after repair
// [R25] Out-of-sequence commands leave flow interrupted
module tnr_maint
   import tnr_pkg::*;
#(
   parameter int unsigned PGM_CYC = `TNR_PGM_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Decoded command bus from the controller
   input wire tnr_cmd_t cmd,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Maintenance results
   output logic victim_refresh,
   output logic [16:0] victim_row,
   output logic [2:0] victim_bank,
   output logic seq_error,
   output logic contents_invalid,
   output logic repair_reset_needed
);
   localparam logic [7:0] MRD_CYC = 8'(`TNR_MRD_CYC); // Mode register delay
   localparam logic [7:0] RP_CYC = 8'(`TNR_RP_CYC); // Precharge time
   localparam logic [31:0] EXIT_CYC = 32'(`TNR_EXIT_CYC);
   localparam logic [31:0] PST_CYC = 32'(`TNR_PST_CYC);

   tnr_trr_t trr_state; // Targeted refresh flow
   tnr_ppr_t ppr_state; // Repair flow
   logic [7:0] rowref_mr; // Row refresh mode register
   logic [7:0] refctl_mr; // Refresh control mode register
   logic [7:0] fused; // One repaired row per bank
   logic [15:0] ref_count; // Normal refresh counter
   logic [7:0] trr_timer; // Flow delays
   logic [31:0] ppr_timer; // Repair delays, long
   logic [1:0] act_cnt; // Activates seen in flow
   logic [1:0] pre_cnt; // Precharges seen in flow or clear
   logic bank_open; // Aggressor bank holds an open row
   logic [2:0] ppr_bank; // Bank under repair

   // Bus write taken only when the command port is quiet, so one writer per cycle
   logic axi_wr;
   assign axi_wr = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~cmd.valid;
   assign s_axi_awready = axi_wr;
   assign s_axi_wready = axi_wr;
   assign s_axi_arready = ~s_axi_rvalid;

   // Mode register write from either source
   logic mrw_v;
   logic [5:0] mrw_ma;
   logic [7:0] mrw_op;
   assign mrw_v = (cmd.valid & cmd.op == TNR_CMD_MRW) | (axi_wr & s_axi_wstrb[0]);
   assign mrw_ma = cmd.valid ? cmd.ma : s_axi_awaddr[7:2];
   assign mrw_op = cmd.valid ? cmd.data : s_axi_wdata[7:0];

   // Decodes that steer the flow
   logic rowref_wr;
   logic on_bank;
   logic is_pre;
   logic trr_tick;
   logic ppr_tick;
   assign rowref_wr = mrw_v & mrw_ma == `TNR_IDX_ROWREF;
   assign on_bank = cmd.bank == rowref_mr[`TNR_ROWREF_BANK_HI:`TNR_ROWREF_BANK_LO];
   assign is_pre = cmd.valid & (cmd.op == TNR_CMD_PRECHARGE_ALL_BANKS | (cmd.op == TNR_CMD_PRE & on_bank)); // R7
   assign trr_tick = trr_timer == 8'h00;
   assign ppr_tick = ppr_timer == 32'h0000_0000;

   // Targeted refresh sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trr_state <= TNR_TRR_IDLE;
         trr_timer <= 8'h00;
         act_cnt <= 2'b00;
         pre_cnt <= 2'b00;
         bank_open <= 1'b0;
      end else begin
         if (!trr_tick) begin
            trr_timer <= trr_timer - 8'h01;
         end
         case (trr_state)
            TNR_TRR_IDLE: begin
               // Entry write sets enable and bank together
               if (rowref_wr && mrw_op[`TNR_ROWREF_EN]) begin // R2
                  trr_state <= TNR_TRR_ENTRY;
                  trr_timer <= MRD_CYC - 8'h01;
                  act_cnt <= 2'b00;
                  pre_cnt <= 2'b00;
                  bank_open <= 1'b0;
               end
            end
            TNR_TRR_ENTRY: begin
               // Any command before the delay spoils the flow
               if (cmd.valid) begin // R9
                  trr_state <= TNR_TRR_BROKEN; // R25
               end else if (trr_tick) begin
                  trr_state <= TNR_TRR_RUN;
               end
            end
            TNR_TRR_RUN: begin
               if (rowref_wr && !mrw_op[`TNR_ROWREF_EN]) begin // R4
                  trr_state <= TNR_TRR_CLEAR;
                  pre_cnt <= 2'b00;
               end else if (mrw_v) begin
                  trr_state <= TNR_TRR_BROKEN; // R25
               end else if (!cmd.valid) begin
                  trr_state <= trr_state;
               end else if (cmd.op == TNR_CMD_ACT && on_bank && !bank_open) begin // R7
                  bank_open <= 1'b1;
                  act_cnt <= act_cnt + 2'b01;
               end else if (is_pre && bank_open) begin
                  bank_open <= 1'b0;
                  pre_cnt <= pre_cnt + 2'b01;
                  if (pre_cnt == 2'b10) begin // R5
                     trr_state <= TNR_TRR_DONE;
                     trr_timer <= RP_CYC + MRD_CYC - 8'h01; // R13
                  end
               end else if (cmd.op == TNR_CMD_ACT && !on_bank && act_cnt == 2'b01) begin // R10
                  trr_state <= TNR_TRR_BROKEN;
               end else if (on_bank || cmd.op == TNR_CMD_REF || cmd.op == TNR_CMD_SRE
                            || cmd.op == TNR_CMD_PRE || cmd.op == TNR_CMD_ACT) begin // R15
                  // Repeated or mismatched pairs also break the flow
                  trr_state <= TNR_TRR_BROKEN; // R25
               end
            end
            TNR_TRR_DONE: begin
               // Disable write or delay expiry ends the mode
               if ((rowref_wr && !mrw_op[`TNR_ROWREF_EN]) || trr_tick) begin // R6
                  trr_state <= TNR_TRR_IDLE;
               end else if (cmd.valid) begin
                  trr_state <= TNR_TRR_BROKEN; // R13
               end
            end
            TNR_TRR_BROKEN: begin
               // Stays interrupted until software disables the mode
               if (rowref_wr && !mrw_op[`TNR_ROWREF_EN]) begin // R14
                  trr_state <= TNR_TRR_CLEAR;
                  pre_cnt <= 2'b00;
               end
            end
            TNR_TRR_CLEAR: begin
               // Three precharges to the bank clear the leftover state
               if (is_pre) begin // R14
                  pre_cnt <= pre_cnt + 2'b01;
                  if (pre_cnt == 2'b10) begin
                     trr_state <= TNR_TRR_IDLE;
                     bank_open <= 1'b0;
                  end
               end
            end
            default: begin
               trr_state <= TNR_TRR_IDLE;
            end
         endcase
      end
   end

   // Completion pulse marks the neighbour rows as restored
   logic trr_complete;
   assign trr_complete = trr_state == TNR_TRR_DONE && trr_tick && !cmd.valid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         victim_refresh <= 1'b0;
         victim_row <= 17'h0_0000;
         victim_bank <= 3'b000;
      end else begin
         victim_refresh <= trr_complete; // R18
         if (trr_state == TNR_TRR_RUN && cmd.valid && cmd.op == TNR_CMD_ACT && on_bank
             && act_cnt == 2'b00) begin
            victim_row <= cmd.row;
            victim_bank <= cmd.bank;
         end
      end
   end

   // Row refresh mode register; self clear and disable write leave bank bits alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rowref_mr <= `TNR_ROWREF_RST;
      end else if (rowref_wr && trr_state != TNR_TRR_IDLE) begin
         rowref_mr[`TNR_ROWREF_EN] <= mrw_op[`TNR_ROWREF_EN]; // R6
      end else if (rowref_wr) begin
         rowref_mr <= mrw_op; // R2
      end else if (trr_complete) begin
         rowref_mr[`TNR_ROWREF_EN] <= 1'b0; // R5
      end
   end

   // Normal refresh counter; flow activates never touch it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_count <= 16'h0000;
      end else if (cmd.valid && cmd.op == TNR_CMD_REF) begin // R16
         ref_count <= ref_count + 16'h0001;
      end
   end

   // Row repair sequencer
   logic refctl_wr;
   assign refctl_wr = mrw_v & mrw_ma == `TNR_IDX_REFCTL;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ppr_state <= TNR_PPR_IDLE;
         ppr_timer <= 32'h0000_0000;
         ppr_bank <= 3'b000;
         fused <= 8'h00;
      end else begin
         if (!ppr_tick) begin
            ppr_timer <= ppr_timer - 32'h0000_0001;
         end
         case (ppr_state)
            TNR_PPR_IDLE: begin
               if (refctl_wr && mrw_op[`TNR_REFCTL_REPAIR]) begin // R20
                  ppr_state <= TNR_PPR_MRD;
                  ppr_timer <= 32'(MRD_CYC) - 32'h0000_0001;
               end
            end
            TNR_PPR_MRD: begin
               if (ppr_tick) begin
                  ppr_state <= TNR_PPR_ARMED;
               end
            end
            TNR_PPR_ARMED: begin
               // Activate names the failed row and starts programming
               if (cmd.valid && cmd.op == TNR_CMD_ACT) begin // R20
                  ppr_state <= TNR_PPR_PGM;
                  ppr_bank <= cmd.bank;
                  ppr_timer <= PGM_CYC - 32'h0000_0001;
               end
            end
            TNR_PPR_PGM: begin
               if (ppr_tick) begin
                  ppr_state <= TNR_PPR_WAITPRE;
               end
            end
            TNR_PPR_WAITPRE: begin
               if (cmd.valid && (cmd.op == TNR_CMD_PRE || cmd.op == TNR_CMD_PRECHARGE_ALL_BANKS)) begin
                  ppr_state <= TNR_PPR_EXIT;
                  fused[ppr_bank] <= 1'b1; // R19
                  ppr_timer <= EXIT_CYC - 32'h0000_0001;
               end
            end
            TNR_PPR_EXIT: begin
               if (ppr_tick) begin
                  ppr_state <= TNR_PPR_WAITCLR;
               end
            end
            TNR_PPR_WAITCLR: begin
               if (refctl_wr && !mrw_op[`TNR_REFCTL_REPAIR]) begin // R21
                  ppr_state <= TNR_PPR_PST;
                  ppr_timer <= PST_CYC - 32'h0000_0001;
               end
            end
            TNR_PPR_PST: begin
               if (ppr_tick) begin
                  ppr_state <= TNR_PPR_NEEDRST;
               end
            end
            TNR_PPR_NEEDRST: begin
               if (cmd.valid && cmd.op == TNR_CMD_RESET) begin // R21
                  ppr_state <= TNR_PPR_IDLE;
               end
            end
            default: begin
               ppr_state <= TNR_PPR_IDLE;
            end
         endcase
      end
   end

   // Refresh control register, repair status flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refctl_mr <= `TNR_REFCTL_RST;
         contents_invalid <= 1'b0;
         repair_reset_needed <= 1'b0;
         seq_error <= 1'b0;
      end else begin
         if (refctl_wr) begin
            refctl_mr <= mrw_op;
         end
         // Contents lost once repair begins; a reset restarts the die
         if (ppr_state == TNR_PPR_MRD) begin
            contents_invalid <= 1'b1; // R24
         end else if (cmd.valid && cmd.op == TNR_CMD_RESET) begin
            contents_invalid <= 1'b0;
         end
         repair_reset_needed <= ppr_state == TNR_PPR_NEEDRST
                                && !(cmd.valid && cmd.op == TNR_CMD_RESET); // R21
         // Sticky until bus reset; any traffic while fusing is flagged
         if ((ppr_state == TNR_PPR_PGM && cmd.valid) || trr_state == TNR_TRR_BROKEN) begin // R23
            seq_error <= 1'b1;
         end
      end
   end

   // Bus write response; read-only or unknown targets answer SLVERR
   logic wr_known;
   assign wr_known = s_axi_awaddr[7:2] == `TNR_IDX_ROWREF || s_axi_awaddr[7:2] == `TNR_IDX_REFCTL;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (axi_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Bus read data, one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr[7:2])
            `TNR_IDX_ROWREF: s_axi_rdata <= {24'h00_0000, rowref_mr};
            `TNR_IDX_REFCTL: s_axi_rdata <= {24'h00_0000, refctl_mr};
            `TNR_IDX_REPAIR: s_axi_rdata <= {24'h00_0000, fused}; // R19
            `TNR_IDX_STATUS: s_axi_rdata <= {18'h0_0000, 1'b0, trr_state, ppr_state,
                                             bank_open, 1'b0, act_cnt, pre_cnt};
            `TNR_IDX_REFCNT: s_axi_rdata <= {16'h0000, ref_count};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : tnr_maint

// ===== tnr_maint_checker.sv
// Checker of the maintenance sequencer, seeing its ports only.
// Assumes one clock domain and a synchronous active low reset.
`timescale 1ns/1ns
module tnr_maint_checker
   import tnr_pkg::*;
#(
   parameter int unsigned PGM_CYC = 20
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Command bus
   input wire tnr_cmd_t cmd,
   // Register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Maintenance results
   input wire logic victim_refresh,
   input wire logic [2:0] victim_bank,
   input wire logic seq_error,
   input wire logic contents_invalid,
   input wire logic repair_reset_needed
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Command classes
   wire cmd_on = cmd.valid;
   wire is_pre = cmd.valid && (cmd.op == TNR_CMD_PRE || cmd.op == TNR_CMD_PRECHARGE_ALL_BANKS);
   wire is_rst = cmd.valid && cmd.op == TNR_CMD_RESET;
   // Bus handshake steps
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   AST_SELF_CLEAR: assert property (
      victim_refresh |-> $past(is_pre, 3) && !$past(cmd_on, 1) && !$past(cmd_on, 2))
      else $error("Refresh pulse not two quiet cycles after a precharge");
   AST_PULSE_ONE: assert property (
      victim_refresh |=> !victim_refresh) else $error("Refresh pulse longer than one cycle");
   AST_BANK_HELD: assert property (
      victim_refresh |-> $stable(victim_bank)) else $error("Victim bank moved at completion");
   AST_ERR_STICKY: assert property (
      seq_error |=> seq_error) else $error("Sequence error dropped");
   AST_RST_CLEARS: assert property (
      is_rst |=> !contents_invalid && !repair_reset_needed) else $error("Reset left repair flags");
   AST_INVALID: assert property (
      repair_reset_needed |-> contents_invalid) else $error("Repair done but contents valid");
   AST_WR_TOGETHER: assert property (
      s_axi_awready |-> s_axi_wready && !cmd_on) else $error("Write accepted beside a command");
   AST_WR_ANSWER: assert property (
      s_wr_take |=> s_axi_bvalid) else $error("Write response late");
   AST_B_HOLD: assert property (
      s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped");
   AST_RD_ANSWER: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("Read data late");
   AST_R_HOLD: assert property (
      s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped");
endmodule : tnr_maint_checker

bind tnr_maint tnr_maint_checker #(.PGM_CYC(PGM_CYC)) u_chk (.*);

// ===== tnr_ctrl_model.sv
// Memory controller model: drives decoded commands, one per cycle.
// Assumes its tasks are called just after a rising edge of aclk.
`timescale 1ns/1ns
`include "tnr_regs.svh"
module tnr_ctrl_model
   import tnr_pkg::*;
#(
   parameter int unsigned PGM_CYC = 20,
   parameter int unsigned RAS_CYC = 2,
   parameter int unsigned RP_CYC = 1
) (
   // Clock
   input wire logic aclk,
   // Decoded commands towards the die
   output tnr_cmd_t cmd
);
   // Quiet bus from time zero
   initial begin
      cmd = '0;
   end
   // One command, taken at the following edge
   task automatic issue(input tnr_op_t op, input logic [2:0] bank, input logic [7:0] data);
      @(posedge aclk);
      cmd <= '{valid: 1'b1, op: op, bank: bank, row: 17'h1_0a5c, ma: `TNR_IDX_ROWREF, data: data};
   endtask : issue
   // Mode register write to a chosen index
   task automatic mrw(input logic [5:0] ma, input logic [7:0] data);
      @(posedge aclk);
      cmd <= '{valid: 1'b1, op: TNR_CMD_MRW, bank: 3'h0, row: 17'h0_0000, ma: ma, data: data};
   endtask : mrw
   // Quiet cycles; the stale row field flips so only valid may qualify it
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge aclk);
         cmd.valid <= 1'b0;
         cmd.row <= ~cmd.row;
      end
   endtask : idle
   // Three pairs after the entry delay; first held open half again row-active time, the others row-active, precharge spacing between
   task automatic pairs(input logic [2:0] bank, input bit last_all);
      idle(1);
      issue(TNR_CMD_ACT, bank, 8'h00);
      idle(RAS_CYC * 3 / 2);
      issue(TNR_CMD_PRE, bank, 8'h00);
      idle(RP_CYC);
      issue(TNR_CMD_ACT, bank, 8'h00);
      idle(RAS_CYC);
      issue(TNR_CMD_PRE, bank, 8'h00);
      idle(RP_CYC);
      issue(TNR_CMD_ACT, bank, 8'h00);
      idle(RAS_CYC);
      issue(last_all ? TNR_CMD_PRECHARGE_ALL_BANKS : TNR_CMD_PRE, bank, 8'h00);
   endtask : pairs
   // Fuse repair of one row; entered only when the bench asks
   task automatic repair(input logic [2:0] bank);
      mrw(`TNR_IDX_REFCTL, 8'h10);
      idle(1);
      issue(TNR_CMD_ACT, bank, 8'h00);
      idle(PGM_CYC + 1);
      issue(TNR_CMD_PRE, bank, 8'h00);
      idle(1);
      mrw(`TNR_IDX_REFCTL, 8'h00);
      idle(1);
   endtask : repair
endmodule : tnr_ctrl_model

// ===== tnr_maint_tb_top.sv
// Self-checking bench of the maintenance sequencer.
// Assumes the controller model on the command bus and the bound checker.
`timescale 1ns/1ns
`include "tnr_regs.svh"
module tnr_maint_tb_top
   import tnr_pkg::*;
();
   localparam int PGM = 20;
   localparam int LIMIT = 20000;
   // Clock, reset and command bus
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   tnr_cmd_t cmd;
   // Register bus
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   // Results and bench counters
   logic victim_refresh, seq_error, contents_invalid, repair_reset_needed;
   logic [16:0] victim_row;
   logic [2:0] victim_bank;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_pulse = 0;
   tnr_maint #(.PGM_CYC(PGM)) dut (.*);
   tnr_ctrl_model #(.PGM_CYC(PGM)) u_ctl (.aclk(aclk), .cmd(cmd));
   // 25 MHz clock
   always #20 aclk = ~aclk;
   // Pulse tally and hang guard
   always @(posedge aclk) begin
      cycles++;
      if (victim_refresh === 1'b1) n_pulse++;
      if (cycles == LIMIT) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk
   // Write with both channels offered together, response awaited
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_awready) @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      chk("rdata", ed, s_axi_rdata);
   endtask : rd
   // Reset values, unmapped and read-only places
   task automatic t_regs;
      rd(8'h10, 32'h0000_0000, 2'b00);
      s_axi_wstrb <= 4'he;
      wr(8'h60, 32'h0000_00ff, 2'b00);
      s_axi_wstrb <= 4'hf;
      rd(8'h60, 32'h0000_0000, 2'b00);
      rd(8'hfc, 32'h0000_0000, 2'b10);
      wr(8'hfc, 32'h0000_00ff, 2'b10);
      wr(8'h64, 32'h0000_00ff, 2'b10);
      rd(8'h64, 32'h0000_0000, 2'b00);
   endtask : t_regs
   // Entry from the bus, last precharge to all banks, then self clear
   task automatic t_good;
      wr(8'h60, 32'h0000_00b0, 2'b00);
      u_ctl.pairs(3'h3, 1'b1);
      u_ctl.idle(5);
      chk("pulses", 32'h1, n_pulse);
      chk("victim_bank", 32'h3, {29'h0, victim_bank});
      rd(8'h60, 32'h0000_0030, 2'b00);
      rd(8'h84, 32'h0000_0000, 2'b00);
      chk("seq_error", 32'h0, {31'h0, seq_error});
      u_ctl.issue(TNR_CMD_REF, 3'h0, 8'h00);
      u_ctl.idle(1);
      rd(8'h84, 32'h0000_0001, 2'b00);
   endtask : t_good
   // Disable write in completion gap: no pulse
   task automatic t_exit;
      u_ctl.mrw(`TNR_IDX_ROWREF, 8'hd0);
      u_ctl.pairs(3'h5, 1'b0);
      u_ctl.mrw(`TNR_IDX_ROWREF, 8'h70);
      u_ctl.idle(5);
      chk("pulses", 32'h1, n_pulse);
      rd(8'h60, 32'h0000_0050, 2'b00);
   endtask : t_exit
   // Fuse repair through to the closing reset command
   task automatic t_repair;
      int k;
      k = 0;
      u_ctl.repair(3'h6);
      while (repair_reset_needed !== 1'b1 && k < 1400) begin
         @(posedge aclk);
         k++;
      end
      chk("reset_needed", 32'h1, {31'h0, repair_reset_needed});
      chk("contents_invalid", 32'h1, {31'h0, contents_invalid});
      rd(8'h64, 32'h0000_0040, 2'b00);
      u_ctl.issue(TNR_CMD_RESET, 3'h0, 8'h00);
      u_ctl.idle(2);
      chk("contents_invalid", 32'h0, {31'h0, contents_invalid});
   endtask : t_repair
   // Refresh breaks flow; clear, rerun
   task automatic t_broken;
      u_ctl.mrw(`TNR_IDX_ROWREF, 8'h90);
      u_ctl.idle(1);
      u_ctl.issue(TNR_CMD_ACT, 3'h1, 8'h00);
      u_ctl.issue(TNR_CMD_REF, 3'h0, 8'h00);
      u_ctl.idle(3);
      chk("seq_error", 32'h1, {31'h0, seq_error});
      u_ctl.mrw(`TNR_IDX_ROWREF, 8'h00);
      repeat (3) begin
         u_ctl.idle(1);
         u_ctl.issue(TNR_CMD_PRE, 3'h1, 8'h00);
      end
      u_ctl.idle(1);
      u_ctl.mrw(`TNR_IDX_ROWREF, 8'h90);
      u_ctl.pairs(3'h1, 1'b0);
      u_ctl.idle(5);
      chk("pulses", 32'h2, n_pulse);
      rd(8'h60, 32'h0000_0010, 2'b00);
   endtask : t_broken
   task automatic give_verdict;
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_good();
      t_exit();
      t_repair();
      t_broken();
      give_verdict();
   end
endmodule : tnr_maint_tb_top
